// >>> src/mac_tx_status.sv
// per-packet transmit status word builder
`timescale 1ns/100ps
`include "tx_status_map.svh"
module mac_tx_status #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES,
  parameter int SIZE_W      = 16
) (
  input  wire  logic                      clk_sys,
  input  wire  logic                      rst_b,
  input  wire  logic                      txStart,
  input  wire  tx_status_pkg::line_type    line,
  input  wire  tx_status_pkg::monitor_type mon,
  input  wire  logic                      fragValid,
  input  wire  logic [SIZE_W-1:0]         fragSize,
  input  wire  logic [SIZE_W-1:0]         pktSize,
  input  wire  logic                      late_collision_reference_select,
  input  wire  logic                      crc_append_inhibit,
  input  wire  logic [1:0]                loopbackMode,
  input  wire  logic                      statusAck,
  output logic                            txAbort,
  output logic                            backoffReq,
  output logic                            crcCheckEnable,
  output logic                            statusWrite,
  output logic [15:0]                     statusWord,
  output logic                            busy
);
  import tx_status_pkg::*;

  // ----------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------
  state_type         state_q, state_d;
  logic [4:0]        collCnt_q;
  logic [15:0]       slotCnt_q;
  logic              slotRun_q;
  logic [SIZE_W-1:0] fragSum_q;
  logic              inCarrierWin_q;
  logic              tooMany_q, lateColl_q, underrun_q, sizeMism_q;
  logic              carrierLost_q, noCarrier_q, deferred_q, tooLongDef_q;
  logic              monBad_q, aborted_q;

  wire active     = (state_q == ST_ACTIVE);
  wire refEvent   = late_collision_reference_select ? line.sfd
                                                    : line.preamble;
  wire slotPassed = slotRun_q && (slotCnt_q >= 16'(SLOT_CYCLES));
  wire collision  = active && line.collision;
  wire tooManyHit = collision && (collCnt_q == `MAX_COLLISIONS - 5'h01);
  wire lateHit    = collision && slotPassed;
  wire underHit   = active && line.fifoEmpty && !line.busGranted;
  wire sizeBad    = active && line.lastByte
                    && (fragSum_q != pktSize);
  wire carrierBad = active && inCarrierWin_q && !line.carrier;
  // loopback forces clean monitor status; code 0 means normal operation
  wire monMask    = crc_append_inhibit
                    || (loopbackMode != 2'b00);
  wire monBadHit  = mon.monDone && !monMask
                    && (mon.alignErr || !mon.addrMatch);
  wire abortNow   = tooManyHit || underHit || sizeBad;
  wire txOk       = !tooMany_q && !tooLongDef_q && !underrun_q;

  assign txAbort        = abortNow;
  // a late collision still backs off, only the count decides abort
  assign backoffReq     = collision && !tooManyHit;
  assign crcCheckEnable = active;
  assign busy           = (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (txStart) state_d = ST_ACTIVE;
      ST_ACTIVE: if (abortNow || line.lastByte) state_d = ST_WRITE;
      ST_WRITE:  if (statusAck) state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      collCnt_q      <= 5'h00;
      slotCnt_q      <= 16'h0000;
      slotRun_q      <= 1'b0;
      fragSum_q      <= '0;
      inCarrierWin_q <= 1'b0;
    end else if (state_q == ST_IDLE && txStart) begin
      collCnt_q      <= 5'h00;
      slotRun_q      <= 1'b0;
      slotCnt_q      <= 16'h0000;
      fragSum_q      <= '0;
      inCarrierWin_q <= 1'b0;
    end else begin
      if (fragValid) fragSum_q <= fragSum_q + fragSize;
      if (collision) collCnt_q <= collCnt_q + 5'h01;
      // slot timer restarts on each attempt's reference point
      if (active && refEvent) begin
        slotRun_q <= 1'b1;
        slotCnt_q <= 16'h0000;
      end else if (slotRun_q && !slotPassed) begin
        slotCnt_q <= slotCnt_q + 16'h0001;
      end
      if (collision) slotRun_q <= 1'b0;
      if (active && line.sfd) inCarrierWin_q <= 1'b1;
      else if (!active || line.lastByte) inCarrierWin_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status flags: cleared at packet start except no-carrier, which is set, and late collision, which is only cleared after write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tooMany_q     <= 1'b0;
      lateColl_q    <= 1'b0;
      underrun_q    <= 1'b0;
      sizeMism_q    <= 1'b0;
      carrierLost_q <= 1'b0;
      noCarrier_q   <= 1'b0;
      deferred_q    <= 1'b0;
      tooLongDef_q  <= 1'b0;
      monBad_q      <= 1'b0;
      aborted_q     <= 1'b0;
    end else if (state_q == ST_IDLE && txStart) begin
      tooMany_q     <= 1'b0;
      underrun_q    <= 1'b0;
      sizeMism_q    <= 1'b0;
      carrierLost_q <= 1'b0;
      noCarrier_q   <= 1'b1;
      deferred_q    <= 1'b0;
      tooLongDef_q  <= 1'b0;
      monBad_q      <= 1'b0;
      aborted_q     <= 1'b0;
    end else begin
      if (tooManyHit) tooMany_q <= 1'b1;
      if (tooManyHit || sizeBad) sizeMism_q <= 1'b1;
      if (underHit) underrun_q <= 1'b1;
      if (carrierBad) carrierLost_q <= 1'b1;
      if (active && line.carrier) noCarrier_q <= 1'b0;
      if (active && line.deferral) deferred_q <= 1'b1;
      if (active && line.tooLongDeferral) tooLongDef_q <= 1'b1;
      if (monBadHit) monBad_q <= 1'b1;
      if (abortNow) aborted_q <= 1'b1;
      // set wins over the post-write clear
      if (lateHit) lateColl_q <= 1'b1;
      else if (state_q == ST_WRITE && statusAck) lateColl_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status word, registered for the descriptor write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      statusWord  <= `STATUS_RESET;
      statusWrite <= 1'b0;
    end else begin
      statusWrite <= (state_d == ST_WRITE);
      if (state_q == ST_WRITE) begin
        statusWord                    <= `STATUS_RESET;
        statusWord[`BIT_TX_OK]        <= txOk && !aborted_q;
        statusWord[`BIT_SIZE_MISM]    <= sizeMism_q;
        statusWord[`BIT_UNDERRUN]     <= underrun_q;
        statusWord[`BIT_MON_BAD]      <= monBad_q && !monMask;
        statusWord[`BIT_RESERVED]     <= 1'b0;
        statusWord[`BIT_LATE_COLL]    <= lateColl_q;
        statusWord[`BIT_TOO_MANY]     <= tooMany_q;
        statusWord[`BIT_CARRIER_LOST] <= carrierLost_q;
        statusWord[`BIT_NO_CARRIER]   <= noCarrier_q;
        statusWord[`BIT_DEFERRED]     <= deferred_q;
        statusWord[`BIT_TOO_LONG_DEF] <= tooLongDef_q;
      end
    end
  end
endmodule : mac_tx_status

// >>> src/tx_status_map.svh
// constants of the transmit status reporting block
`ifndef TX_STATUS_MAP_SVH
`define TX_STATUS_MAP_SVH
`define BIT_TX_OK        0
`define BIT_SIZE_MISM    1
`define BIT_UNDERRUN     2
`define BIT_MON_BAD      3
`define BIT_RESERVED     4
`define BIT_LATE_COLL    5
`define BIT_TOO_MANY     6
`define BIT_CARRIER_LOST 7
`define BIT_NO_CARRIER   8
`define BIT_DEFERRED     9
`define BIT_TOO_LONG_DEF 10
`define STATUS_RESET     16'h0000
`define MAX_COLLISIONS   5'h10
`define SLOT_TIME_NS     51200
`define CLK_PERIOD_NS    8
`define SLOT_CYCLES      (`SLOT_TIME_NS / `CLK_PERIOD_NS)
`endif

// >>> src/tx_status_pkg.sv
// types of the transmit status reporting block
package tx_status_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_WRITE  = 2'b10
  } state_type;

  typedef struct packed {
    logic preamble;
    logic sfd;
    logic lastByte;
    logic collision;
    logic carrier;
    logic fifoEmpty;
    logic busGranted;
    logic deferral;
    logic tooLongDeferral;
  } line_type;

  typedef struct packed {
    logic monDone;
    logic alignErr;
    logic addrMatch;
  } monitor_type;
endpackage : tx_status_pkg

// >>> testbench/mac_tx_status_chk.sv
// port assertions of the transmit status block
`timescale 1ns/100ps
module mac_tx_status_chk (
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire tx_status_pkg::line_type line,
  input wire logic                    crc_append_inhibit,
  input wire logic [1:0]              loopbackMode,
  input wire logic                    statusAck,
  input wire logic                    txAbort,
  input wire logic                    backoffReq,
  input wire logic                    crcCheckEnable,
  input wire logic                    statusWrite,
  input wire logic [15:0]             statusWord,
  input wire logic                    busy
);
  import tx_status_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // the word lands one cycle after posting starts
  sequence s_post;
    $rose(statusWrite) ##1 1'b1;
  endsequence
  a_crc_on_send: assert property (
    (busy && !statusWrite) |-> crcCheckEnable)
    else $error("crc checker idle while sending");
  a_inhibit_mask: assert property (
    crc_append_inhibit throughout s_post |-> !statusWord[3])
    else $error("monitored bad with crc inhibited");
  a_loop_mask: assert property (
    (loopbackMode != 2'b00) throughout s_post |-> !statusWord[3])
    else $error("monitored bad in loopback");
  a_ok_clean: assert property (s_post |-> !(statusWord[0] &&
    (statusWord[10] | statusWord[6] | statusWord[2]))) else $error("ok flag");
  a_many_mismatch: assert property (s_post |->
    (!statusWord[6] || statusWord[1])) else $error("mismatch missing");
  a_abort_post: assert property (txAbort |=> statusWrite)
    else $error("abort not posted");
  a_late_backoff: assert property ((crcCheckEnable &&
    line.collision && !txAbort) |-> backoffReq)
    else $error("collision without backoff");
  a_write_hold: assert property ((statusWrite && !statusAck) |=>
    statusWrite) else $error("posting dropped before ack");
endmodule : mac_tx_status_chk
bind mac_tx_status mac_tx_status_chk i_chk (.clk_sys, .rst_b, .line,
  .crc_append_inhibit, .loopbackMode, .statusAck, .txAbort, .backoffReq,
  .crcCheckEnable, .statusWrite, .statusWord, .busy);

// >>> testbench/tx_host_model.sv
// host side: takes each posted status word and acknowledges it
`timescale 1ns/100ps
module tx_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        statusWrite,
  input  wire logic [15:0] statusWord,
  input  wire logic [3:0]  ackDelay,
  input  wire logic        rxFifoOverrun,
  output logic             statusAck,
  output logic [15:0]      postedWord,
  output logic             monBadUsable
);
  logic [3:0] cnt_q;
  logic       done_q;
  wire        go = statusWrite && !done_q && cnt_q == ackDelay;
  // incomplete monitoring makes the flag void
  assign monBadUsable = postedWord[3] & ~rxFifoOverrun;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_q, done_q, statusAck, postedWord} <= '0;
    end else begin
      statusAck <= go;
      if (go) postedWord <= statusWord;
      if (!statusWrite) {cnt_q, done_q} <= '0;
      else {cnt_q, done_q} <= {cnt_q + {3'b0, !done_q}, done_q | go};
    end
  end
endmodule : tx_host_model

// >>> testbench/test_mac_tx_status_reporting.sv
// self-checking bench of the transmit status block
`timescale 1ns/100ps
module test_mac_tx_status_reporting;
  import tx_status_pkg::*;
  logic clk_sys = 0, rst_b = 0, txStart = 0, fragValid = 0, busy;
  logic crc_append_inhibit = 0, late_collision_reference_select = 0;
  logic [1:0] loopbackMode = 0;
  logic [3:0] ackDelay = 4'h1;
  logic rxOvr = 1'b0;
  logic [15:0] fragSize = 0, pktSize = 16'h0040, postedWord, statusWord;
  line_type line = '0;
  monitor_type mon = '0;
  logic txAbort, backoffReq, crcCheckEnable, statusWrite, statusAck, mbu;
  int err_total = 0, checks = 0;
  always #4 clk_sys = ~clk_sys;
  mac_tx_status #(.SLOT_CYCLES(20)) i_dut (.clk_sys, .rst_b, .txStart,
    .line, .mon, .fragValid, .fragSize, .pktSize, .statusAck, .loopbackMode,
    .late_collision_reference_select, .crc_append_inhibit, .txAbort,
    .backoffReq, .crcCheckEnable, .statusWrite, .statusWord, .busy);
  tx_host_model i_host (.clk_sys, .rst_b, .statusWrite, .statusWord,
    .ackDelay, .rxFifoOverrun(rxOvr), .statusAck, .postedWord,
    .monBadUsable(mbu));
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic pkt(input logic [15:0] fsz, input int ncol, gap,
                     input logic car, bad, und);
    @(posedge clk_sys) txStart <= 1'b1;
    @(posedge clk_sys) txStart <= 1'b0;
    fragValid <= 1'b1;
    fragSize <= fsz;
    @(posedge clk_sys) fragValid <= 1'b0;
    line.preamble <= 1'b1;
    @(posedge clk_sys) line.preamble <= 1'b0;
    line.sfd <= 1'b1;
    line.carrier <= car;
    @(posedge clk_sys) line.sfd <= 1'b0;
    repeat (gap) @(posedge clk_sys);
    repeat (ncol) begin
      line.collision <= 1'b1;
      @(posedge clk_sys) line.collision <= 1'b0;
      @(posedge clk_sys);
    end
    line.fifoEmpty <= und;
    line.busGranted <= !und;
    line.lastByte <= !und && ncol < 16;
    // monitor verdict arrives with the last byte, before the word is built
    mon <= '{1'b1, bad, !bad};
    @(posedge clk_sys) line <= '{busGranted: 1'b1, default: 1'b0};
    mon <= '0;
    @(posedge clk_sys);
  endtask : pkt
  task automatic fin(input logic [15:0] mask, exp);
    int i;
    for (i = 0; i < 300 && statusAck !== 1'b1; i++) @(negedge clk_sys);
    if (statusAck !== 1'b1) begin
      err_total++;
      complete_run();
    end
    check("statusWord", postedWord & mask, exp);
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys);
    check("busy", {15'h0, busy}, 16'h0000);
  endtask : fin
  initial begin
    line.busGranted = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    pkt(16'h0040, 0, 0, 1, 0, 0);
    fin(16'hffff, 16'h0001);
    pkt(16'h0040, 0, 0, 1, 1, 0);
    fin(16'h0008, 16'h0008);
    check("monBadUsable", {15'h0, mbu}, 16'h0001);
    @(posedge clk_sys) rxOvr <= 1'b1;
    @(negedge clk_sys);
    check("monBadUsable", {15'h0, mbu}, 16'h0000);
    @(posedge clk_sys) rxOvr <= 1'b0;
    crc_append_inhibit <= 1'b1;
    pkt(16'h0040, 0, 0, 1, 1, 0);
    fin(16'h0008, 16'h0000);
    crc_append_inhibit <= 1'b0;
    for (int m = 1; m < 4; m++) begin
      loopbackMode <= m[1:0];
      pkt(16'h0040, 0, 0, 1, 1, 0);
      fin(16'h0008, 16'h0000);
    end
    loopbackMode <= 2'b00;
    ackDelay <= 4'h6;
    pkt(16'h003c, 0, 0, 1, 0, 0);
    fin(16'h0002, 16'h0002);
    pkt(16'h0040, 0, 0, 1, 0, 1);
    fin(16'h0005, 16'h0004);
    pkt(16'h0040, 16, 2, 1, 0, 0);
    fin(16'h0043, 16'h0042);
    pkt(16'h0040, 0, 0, 0, 0, 0);
    fin(16'h0181, 16'h0181);
    pkt(16'h0040, 1, 2, 1, 0, 0);
    fin(16'h0021, 16'h0001);
    pkt(16'h0040, 1, 30, 1, 0, 0);
    fin(16'h0020, 16'h0020);
    pkt(16'h0040, 0, 0, 1, 0, 0);
    fin(16'hffff, 16'h0001);
    complete_run();
  end
endmodule : test_mac_tx_status_reporting
